// file: rtl/cms_clock_ctrl.sv
/*
 * Clock multiplier control and clock source selection with its two
 * special function registers.
 * Assumes a single-cycle SFR bus on core_clk, an analog multiplier
 * and oscillator pads that return asynchronous lock/settle levels.
 */
`timescale 1ns/1ps
`include "cms_params.svh"

module cms_clock_ctrl
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic int_osc_en,
    input wire logic ext_osc_en,
    input wire logic mul_lock_async,
    input wire logic xtal_settled_async,
    output logic mul_enable,
    output logic mul_init_pulse,
    output cms_pkg::cms_mul_in_t mul_input_sel,
    output cms_pkg::cms_sys_sel_t sys_clk_sel,
    output cms_pkg::cms_usb_sel_t usb_clk_sel,
    output logic crystal_valid_flag,
    output logic int_osc_usable,
    output logic ext_periph_clk_en
);
    import cms_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic mul_en_r;
    logic mul_en_nxt;
    logic mul_init_r;
    logic mul_init_nxt;
    logic init_pulse_r;
    logic init_pulse_nxt;
    logic [1:0] mul_sel_r;
    logic [1:0] mul_sel_nxt;
    logic [2:0] usb_sel_r;
    logic [2:0] usb_sel_nxt;
    logic [1:0] sys_sel_r;
    logic [1:0] sys_sel_nxt;
    logic lock_meta_r;
    logic lock_sync_r;
    logic xtal_meta_r;
    logic xtal_sync_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    wire wr_mul = sfr_wr && (sfr_addr == `CMS_ADDR_MUL_CTRL);
    wire wr_src = sfr_wr && (sfr_addr == `CMS_ADDR_CLK_SRC);
    wire rd_mul = sfr_rd && (sfr_addr == `CMS_ADDR_MUL_CTRL);
    wire rd_src = sfr_rd && (sfr_addr == `CMS_ADDR_CLK_SRC);
    wire mul_rdy;
    wire start_init;
    wire [7:0] mul_view;
    wire [7:0] src_view;

    // ****************************************************************
    // Multiplier control
    // ****************************************************************
    // Enable follows bit 7
    assign mul_en_nxt = wr_mul ? sfr_wdata[`CMS_MUL_EN_BIT] : mul_en_r;
    assign start_init = wr_mul && mul_en_r
        && sfr_wdata[`CMS_MUL_EN_BIT] && sfr_wdata[`CMS_MUL_INIT_BIT];
    // Init in the enabling write is ignored
    assign mul_init_nxt = !mul_en_nxt ? 1'b0 :
        (start_init ? 1'b1 : mul_init_r);
    assign init_pulse_nxt = start_init && !mul_init_r;
    assign mul_sel_nxt = wr_mul ?
        sfr_wdata[`CMS_MUL_SEL_HI:`CMS_MUL_SEL_LO] : mul_sel_r;
    // Ready only when enabled, initialised and locked
    assign mul_rdy = mul_en_r && mul_init_r && lock_sync_r;

    // ****************************************************************
    // Clock source selection
    // ****************************************************************
    // USB source field
    assign usb_sel_nxt = wr_src ?
        sfr_wdata[`CMS_USB_SEL_HI:`CMS_USB_SEL_LO] : usb_sel_r;
    // System source may change at any write
    assign sys_sel_nxt = wr_src ?
        sfr_wdata[`CMS_SYS_SEL_HI:`CMS_SYS_SEL_LO] : sys_sel_r;

    // ****************************************************************
    // Read views, unused bits read zero
    // ****************************************************************
    assign mul_view = {mul_en_r, mul_init_r, mul_rdy, 3'h0, mul_sel_r};
    assign src_view = {1'b0, usb_sel_r, 2'h0, sys_sel_r};
    assign rdata_nxt = rd_mul ? mul_view : (rd_src ? src_view : 8'h00);

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            mul_en_r <= 1'b0;
            mul_init_r <= 1'b0;
            init_pulse_r <= 1'b0;
            mul_sel_r <= 2'h0;
            usb_sel_r <= 3'h0;
            sys_sel_r <= 2'h0;
            rdata_r <= 8'h00;
        end
        else
        begin
            mul_en_r <= mul_en_nxt;
            mul_init_r <= mul_init_nxt;
            init_pulse_r <= init_pulse_nxt;
            mul_sel_r <= mul_sel_nxt;
            usb_sel_r <= usb_sel_nxt;
            sys_sel_r <= sys_sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Two-stage synchronisers for pad levels
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lock_meta_r <= 1'b0;
            lock_sync_r <= 1'b0;
            xtal_meta_r <= 1'b0;
            xtal_sync_r <= 1'b0;
        end
        else
        begin
            lock_meta_r <= mul_lock_async;
            lock_sync_r <= lock_meta_r;
            xtal_meta_r <= xtal_settled_async;
            xtal_sync_r <= xtal_meta_r;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign sfr_rdata = rdata_r;
    assign mul_enable = mul_en_r;
    assign mul_init_pulse = init_pulse_r;
    assign mul_input_sel = cms_mul_in_t'(mul_sel_r);
    // External drives system clock only at code 01
    assign sys_clk_sel = cms_sys_sel_t'(sys_sel_r);
    assign usb_clk_sel = cms_usb_sel_t'(usb_sel_r);
    assign crystal_valid_flag = ext_osc_en && xtal_sync_r;
    // No settling wait for internal oscillator
    assign int_osc_usable = int_osc_en;
    // Peripheral feed independent of system select
    assign ext_periph_clk_en = ext_osc_en;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_enable_follows: assert property (
        @(posedge core_clk) disable iff (rst)
        wr_mul |=> (mul_enable == $past(sfr_wdata[`CMS_MUL_EN_BIT])))
        else $error("enable does not follow written bit");
    chk_init_pulse_on: assert property (
        @(posedge core_clk) disable iff (rst)
        (wr_mul && mul_en_r && sfr_wdata[7] && sfr_wdata[6]
            && !mul_init_r) |=> mul_init_pulse ##1 !mul_init_pulse)
        else $error("init pulse missing or too long");
    chk_init_needs_enable: assert property (
        @(posedge core_clk) disable iff (rst)
        (wr_mul && !mul_en_r) |=> !mul_init_pulse && !mul_init_r)
        else $error("init taken in the enabling write");
    chk_ready_read: assert property (
        @(posedge core_clk) disable iff (rst)
        rd_mul |=> (sfr_rdata[`CMS_MUL_RDY_BIT] ==
            $past(mul_en_r && mul_init_r && lock_sync_r)))
        else $error("ready bit reads wrong");
    chk_ready_lock: assert property (
        @(posedge core_clk) disable iff (rst)
        (mul_en_r && mul_init_r && !mul_lock_async)[*3] |-> !mul_rdy)
        else $error("ready without lock");
    chk_input_sel: assert property (
        @(posedge core_clk) disable iff (rst)
        wr_mul |=> (mul_input_sel == $past(sfr_wdata[1:0])))
        else $error("multiplier input select wrong");
    chk_int_osc_now: assert property (
        @(posedge core_clk) disable iff (rst)
        $rose(int_osc_en) |-> int_osc_usable)
        else $error("internal oscillator delayed");
    chk_xtal_valid: assert property (
        @(posedge core_clk) disable iff (rst)
        (ext_osc_en && xtal_settled_async)[*3] |-> crystal_valid_flag)
        else $error("crystal valid not set");
    chk_sys_select: assert property (
        @(posedge core_clk) disable iff (rst)
        wr_src |=> (sys_clk_sel == $past(sfr_wdata[1:0])) &&
            (usb_clk_sel == $past(sfr_wdata[6:4])))
        else $error("clock source select wrong");
    chk_periph_ext: assert property (
        @(posedge core_clk) disable iff (rst)
        (sys_clk_sel == CMS_SYS_INT) |-> (ext_periph_clk_en == ext_osc_en))
        else $error("peripheral external feed lost");
    chk_unused_zero: assert property (
        @(posedge core_clk) disable iff (rst)
        (rd_src ##1 1'b1) |-> (sfr_rdata[7] == 1'b0) &&
            (sfr_rdata[3:2] == 2'h0))
        else $error("unused bits not zero");

    cov_bring_up: cover property (
        @(posedge core_clk) disable iff (rst)
        mul_init_pulse ##[1:20] mul_rdy);
    cov_usb_mul: cover property (
        @(posedge core_clk) disable iff (rst)
        mul_rdy && usb_clk_sel == CMS_USB_MUL);
    cov_sys_switch: cover property (
        @(posedge core_clk) disable iff (rst)
        sys_clk_sel == CMS_SYS_INT ##1 sys_clk_sel == CMS_SYS_MUL_DIV2);
endmodule // cms_clock_ctrl

// file: rtl/cms_params.svh
/*
 * Constants of the clock multiplier and clock select block.
 * Assumes the includers are the block's own module and its bench; no processes here.
 */
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// ****************************************************************
// Register addresses and reset values
// ****************************************************************
`define CMS_ADDR_MUL_CTRL 8'hb9
`define CMS_ADDR_CLK_SRC 8'ha9
`define CMS_MUL_CTRL_RST 8'h00
`define CMS_CLK_SRC_RST 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define CMS_MUL_EN_BIT 7
`define CMS_MUL_INIT_BIT 6
`define CMS_MUL_RDY_BIT 5
`define CMS_MUL_SEL_HI 1
`define CMS_MUL_SEL_LO 0
`define CMS_USB_SEL_HI 6
`define CMS_USB_SEL_LO 4
`define CMS_SYS_SEL_HI 1
`define CMS_SYS_SEL_LO 0

// ****************************************************************
// Software waits, in core_clk cycles
// ****************************************************************
// Crystal settling wait, 1 ms
`define CMS_XTAL_WAIT_CYC 40000
// Enable to init wait, just over 5 us
`define CMS_MUL_EN_WAIT_CYC 201

`endif

// file: rtl/cms_pkg.sv
/*
 * Types of the clock multiplier and clock select block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cms_pkg;
    // Multiplier input source, code order matches the field
    typedef enum logic [1:0] {
        CMS_MIN_INT,
        CMS_MIN_EXT,
        CMS_MIN_EXT_DIV2,
        CMS_MIN_RSVD
    } cms_mul_in_t;
    // System clock source
    typedef enum logic [1:0] {
        CMS_SYS_INT,
        CMS_SYS_EXT,
        CMS_SYS_MUL_DIV2,
        CMS_SYS_RSVD
    } cms_sys_sel_t;
    // USB clock source
    typedef enum logic [2:0] {
        CMS_USB_MUL,
        CMS_USB_INT_DIV2,
        CMS_USB_EXT,
        CMS_USB_EXT_DIV2,
        CMS_USB_EXT_DIV3,
        CMS_USB_EXT_DIV4,
        CMS_USB_RSVD6,
        CMS_USB_RSVD7
    } cms_usb_sel_t;
endpackage

// file: verification/cms_osc_model.sv
/* Oscillator pads and multiplier analog model.
   Assumes core_clk of the block under test. */
`timescale 1ns/1ps
module cms_osc_model
#(
    parameter int LOCK_DLY = 10,
    parameter int XTAL_DLY = 20
)
(
    input wire logic core_clk,
    input wire logic mul_enable,
    input wire logic mul_init_pulse,
    input wire logic ext_osc_en,
    output logic mul_lock_async,
    output logic xtal_settled_async
);
    int lock_cnt_r = 0;
    int xtal_cnt_r = 0;
    always @(posedge core_clk)
    begin
        xtal_cnt_r <= ext_osc_en ? xtal_cnt_r + 1 : 0;
        if (!mul_enable)
            lock_cnt_r <= 0;
        else if (mul_init_pulse || lock_cnt_r > 0)
            lock_cnt_r <= lock_cnt_r + 1;
    end
    assign mul_lock_async = lock_cnt_r > LOCK_DLY;
    assign xtal_settled_async = xtal_cnt_r > XTAL_DLY;
endmodule // cms_osc_model

// file: verification/tb_cms_clock_ctrl.sv
/* Self-checking bench of the clock control block.
   Assumes the oscillator model stands in for the analog pads. */
`timescale 1ns/1ps
`include "cms_params.svh"
module tb_cms_clock_ctrl;
    import cms_pkg::*;
    logic core_clk = 0;
    logic rst = 1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 0;
    logic sfr_rd = 0;
    logic [7:0] sfr_wdata = 8'h00;
    logic int_osc_en = 0;
    logic ext_osc_en = 0;
    logic [7:0] sfr_rdata;
    logic [7:0] rd_val;
    logic mul_lock_async, xtal_settled_async, mul_enable, mul_init_pulse;
    logic crystal_valid_flag, int_osc_usable, ext_periph_clk_en;
    cms_mul_in_t mul_input_sel;
    cms_sys_sel_t sys_clk_sel;
    cms_usb_sel_t usb_clk_sel;
    int err_count = 0;
    int num_checks = 0;
    cms_clock_ctrl u_cms_clock_ctrl (.core_clk, .rst, .sfr_addr, .sfr_wr,
        .sfr_rd, .sfr_wdata, .sfr_rdata, .int_osc_en, .ext_osc_en,
        .mul_lock_async, .xtal_settled_async, .mul_enable, .mul_init_pulse,
        .mul_input_sel, .sys_clk_sel, .usb_clk_sel, .crystal_valid_flag,
        .int_osc_usable, .ext_periph_clk_en);
    cms_osc_model u_cms_osc_model (.core_clk, .mul_enable, .mul_init_pulse,
        .ext_osc_en, .mul_lock_async, .xtal_settled_async);
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        #1;
        rd_val = sfr_rdata;
    endtask
    task automatic complete_run();
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd(8'hb9);
        chk(rd_val, 8'h00);
        rd(8'h55);
        chk(rd_val, 8'h00);
        rd(8'ha9);
        chk(rd_val, 8'h00);
        chk({mul_enable, mul_init_pulse, usb_clk_sel}, 8'h00);
    endtask
    task automatic t_refuse();
        wr(8'hb9, 8'hff);
        chk(mul_init_pulse, 8'h00);
        chk(mul_enable, 8'h01);
        chk(mul_input_sel, 8'h03);
        rd(8'hb9);
        chk(rd_val, 8'h83);
        wr(8'hb9, 8'h00);
        chk(mul_enable, 8'h00);
    endtask
    task automatic t_crystal();
        @(posedge core_clk);
        int_osc_en <= 1'b1;
        ext_osc_en <= 1'b1;
        #1;
        chk(int_osc_usable, 8'h01);
        chk(ext_periph_clk_en, 8'h01);
        chk(crystal_valid_flag, 8'h00);
        repeat (`CMS_XTAL_WAIT_CYC) @(posedge core_clk);
        #1;
        chk(crystal_valid_flag, 8'h01);
    endtask
    task automatic t_bringup(input logic [7:0] s);
        int n;
        wr(8'hb9, 8'h00);
        wr(8'hb9, s);
        chk(mul_input_sel, s);
        wr(8'hb9, 8'h80 | s);
        repeat (`CMS_MUL_EN_WAIT_CYC) @(posedge core_clk);
        wr(8'hb9, 8'hc0 | s);
        chk(mul_init_pulse, 8'h01);
        rd(8'hb9);
        chk(rd_val, 8'hc0 | s);
        for (n = 0; n < 40 && rd_val[5] !== 1'b1; n++)
            rd(8'hb9);
        chk(rd_val, 8'he0 | s);
        wr(8'ha9, 8'h00);
        chk(usb_clk_sel, 8'h00);
    endtask
    task automatic t_select();
        for (int i = 0; i < 8; i++)
        begin
            wr(8'ha9, 8'h8c | 8'(i * 17));
            chk(usb_clk_sel, 8'(i));
            chk(sys_clk_sel, 8'(i % 4));
            rd(8'ha9);
            chk(rd_val, 8'(i * 16 + i % 4));
        end
    endtask
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_refuse();
        t_crystal();
        for (int s = 0; s < 3; s++)
            t_bringup(8'(s));
        t_select();
        complete_run();
    end
endmodule // tb_cms_clock_ctrl
